// ===== verification/hw_config_fields_mid_bench.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================================================
// Bench
module hw_config_fields_mid_bench
  import hwcfg_pkg::*;
;
  logic clk = 1'b0, reset = 1'b1, por = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, phy_source_pin = 1'b0, rx_fifo_empty = 1'b1;
  logic bulk_in_token, tx_frame_checker_sync_lost, req_token = 1'b0, req_sync = 1'b0;
  logic out_pipe_stall, out_stall_clear = 1'b0, rx_in_valid = 1'b0, rx_in_sop = 1'b0, rx_in_error = 1'b0;
  logic rx_in_ready, rx_out_valid, rx_out_sop, frame_dropped, activity = 1'b0, activity_led;
  logic phy_irq_int_n = 1'b0, phy_irq_n, phy_irq_oe_n;
  logic [1:0] hs_drive_boost;
  logic [7:0] rx_in_data = 8'hA5, rx_out_data, mii_int_out = 8'h5A, gpio_out = 8'h33;
  logic [7:0] gpio_oe_n = 8'hF0, mii_pin_out, mii_pin_oe_n;
  hwcfg_reply_t in_reply, last_reply;
  int error_cnt = 0, checked = 0, cyc = 0;

  // Block with a short slow LED period, and the host model
  hwcfg_top #(.LED_SLOW_CYC(100)) hwcfg_top_i (.*);
  hwcfg_usb_host_model hwcfg_usb_host_model_i (.*);

  // Clock
  initial forever #5 clk = ~clk;

  // Hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      error_cnt++;
      $display("BAD %0t timeout", $time);
      print_verdict;
    end
  end

  task automatic print_verdict;
    if (error_cnt == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  // APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic p_rst(input logic p);
    @(posedge clk);
    reset <= !p;
    por <= p;
    @(posedge clk);
    reset <= 1'b0;
    por <= 1'b0;
  endtask

  task automatic t_regs;
    apb(1'b0, HWCFG_ADDR_SETUP, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, HWCFG_ADDR_SETUP, 32'h7FC4);
    apb(1'b0, HWCFG_ADDR_SETUP, 32'h0);
    chk(rd, 32'h7FC0);
    apb(1'b0, 12'h020, 32'h0);
    chk({er, rd[30:0]}, 32'h8000_0000);
  endtask

  task automatic t_boost;
    for (int b = 0; b < 4; b++)
    begin
      apb(1'b1, HWCFG_ADDR_SETUP, b << 13);
      repeat (2) @(posedge clk);
      chk(hs_drive_boost, b);
    end
  endtask

  task automatic t_guard;
    logic [31:0] w [3] = '{32'hD000, 32'h2000, 32'hE000};
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, HWCFG_ADDR_SETUP, w[i]);
      p_rst(i == 2);
      apb(1'b0, HWCFG_ADDR_SETUP, 32'h0);
      chk(rd, i == 0 ? 32'hC000 : 32'h0);
    end
  endtask

  task automatic t_reply;
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, HWCFG_ADDR_SETUP, (i == 1) << 12);
      rx_fifo_empty <= (i != 2);
      req_token <= 1'b1;
      @(posedge clk);
      req_token <= 1'b0;
      repeat (4) @(posedge clk);
      chk(last_reply, i == 2 ? HWCFG_REPLY_NONE : i == 1 ? HWCFG_REPLY_NAK : HWCFG_REPLY_ZLP);
    end
  endtask

  task automatic t_stall;
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, HWCFG_ADDR_SETUP, (i == 1) << 8);
      req_sync <= 1'b1;
      @(posedge clk);
      req_sync <= 1'b0;
      repeat (3) @(posedge clk);
      apb(1'b0, HWCFG_ADDR_EVENTS, 32'h0);
      chk({out_pipe_stall, rd[0]}, {2{i != 1}});
      if (i == 0)
        apb(1'b1, HWCFG_ADDR_EVENTS, 32'h1);
      out_stall_clear <= (i == 2);
      @(posedge clk);
      out_stall_clear <= 1'b0;
      repeat (2) @(posedge clk);
      chk(out_pipe_stall, 1'b0);
    end
  endtask

  task automatic t_led(input logic f, input int lo, input int hi);
    int n;
    apb(1'b1, HWCFG_ADDR_SETUP, f << 11);
    repeat (hi) @(posedge clk);
    activity <= 1'b1;
    @(posedge clk);
    activity <= 1'b0;
    n = 0;
    while (activity_led !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    n = 0;
    while (activity_led === 1'b1 && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
    chk(n >= lo && n <= hi, 1'b1);
  endtask

  // One start byte; pads then data come out, or the byte is dropped
  task automatic t_rx(input int s, input logic e);
    int k, d;
    k = 0;
    d = 0;
    apb(1'b1, HWCFG_ADDR_SETUP, (s << 9) | (e << 6));
    rx_in_valid <= 1'b1;
    rx_in_sop <= 1'b1;
    rx_in_error <= e;
    repeat (12)
    begin
      @(posedge clk);
      if (rx_in_ready === 1'b1)
        rx_in_valid <= 1'b0;
      d += (frame_dropped === 1'b1);
      if (rx_out_valid === 1'b1)
      begin
        chk({rx_out_sop, rx_out_data}, {k == 0 || k == s, k < s ? 8'h00 : 8'hA5});
        k++;
      end
    end
    chk(k, e ? 0 : s + 1);
    chk(d, e);
    rx_in_error <= 1'b0;
  endtask

  task automatic t_mii;
    gpio_oe_n <= 8'h0F;
    apb(1'b1, HWCFG_ADDR_SETUP, 32'h80);
    repeat (3) @(posedge clk);
    chk({mii_pin_oe_n, mii_pin_out, phy_irq_oe_n, phy_irq_n}, {8'h00, 8'h5A, 2'h0});
    phy_source_pin <= 1'b1;
    repeat (6) @(posedge clk);
    apb(1'b0, HWCFG_ADDR_SETUP, 32'h0);
    chk(rd, 32'h84);
    chk({mii_pin_oe_n, phy_irq_oe_n}, {8'h0F, 1'b1});
    phy_source_pin <= 1'b0;
    apb(1'b1, HWCFG_ADDR_SETUP, 32'h0);
    repeat (6) @(posedge clk);
    chk({mii_pin_oe_n, phy_irq_oe_n}, {8'h0F, 1'b1});
  endtask

  // Main sequence
  initial
  begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    por <= 1'b0;
    t_regs;
    t_boost;
    t_guard;
    t_reply;
    t_stall;
    t_led(1'b0, 90, 110);
    t_led(1'b1, 1400, 1600);
    for (int s = 0; s < 4; s++)
      t_rx(s, 1'b0);
    t_rx(0, 1'b1);
    t_mii;
    print_verdict;
  end
endmodule // hw_config_fields_mid_bench
`default_nettype wire

// ===== verification/hwcfg_checker.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================================================
// Checker of the configuration fields
module hwcfg_checker
  import hwcfg_pkg::*;
(
  // Clock and resets
  input wire logic clk,
  input wire logic reset,
  input wire logic por,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  // USB side
  input wire logic bulk_in_token,
  input wire logic rx_fifo_empty,
  input wire hwcfg_reply_t in_reply,
  input wire logic tx_frame_checker_sync_lost,
  input wire logic out_pipe_stall,
  input wire logic [1:0] hs_drive_boost,
  // Receive path
  input wire logic rx_in_valid,
  input wire logic rx_in_ready,
  input wire logic rx_in_error,
  input wire logic frame_dropped,
  // Pins
  input wire logic phy_source_pin,
  input wire logic [7:0] gpio_oe_n,
  input wire logic [7:0] mii_pin_oe_n,
  input wire logic phy_irq_oe_n
);
  logic [3:0] sh;
  logic g;
  wire logic wr = psel && penable && pready && pwrite && paddr == HWCFG_ADDR_SETUP;

  default clocking @(posedge clk); endclocking
  default disable iff (reset || por);

  // Copy of reply, inhibit, exposure and drop bits
  always_ff @(posedge clk)
  begin
    if (reset || por)
      sh <= 4'h0;
    else if (wr)
      sh <= {pwdata[12], pwdata[8], pwdata[7], pwdata[6]};
  end

  // Copy of the guard bit, which survives plain resets while set
  always_ff @(posedge clk)
  begin
    if (por || (reset && !g))
      g <= 1'b0;
    else if (wr)
      g <= pwdata[15];
  end

  a_reply_given:
    assert property (bulk_in_token && rx_fifo_empty |=> in_reply == ($past(sh[3]) ? HWCFG_REPLY_NAK : HWCFG_REPLY_ZLP))
    else $error("wrong reply to bulk IN on empty FIFO");
  a_reply_idle:
    assert property (!(bulk_in_token && rx_fifo_empty) |=> in_reply == HWCFG_REPLY_NONE)
    else $error("reply without an empty bulk IN");
  a_apb_wait:
    assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("APB answer timing wrong");
  a_stall_set:
    assert property (tx_frame_checker_sync_lost && !sh[2] |=> out_pipe_stall)
    else $error("sync loss did not stall");
  a_stall_inhibit:
    assert property (tx_frame_checker_sync_lost && sh[2] && !out_pipe_stall |=> !out_pipe_stall)
    else $error("stall despite inhibit");
  a_guard_keep:
    assert property (disable iff (por) reset && g |=> $stable(hs_drive_boost))
    else $error("guarded boost lost on reset");
  a_boost_por:
    assert property (disable iff (reset) por |=> hs_drive_boost == 2'h0)
    else $error("boost kept over power-on reset");
  a_mii_expose:
    assert property ((sh[1] && !phy_source_pin) [*5] |-> mii_pin_oe_n == 8'h00 && !phy_irq_oe_n)
    else $error("exposed pins not driven");
  a_mii_external:
    assert property ((phy_source_pin && $stable(gpio_oe_n)) [*6] |-> mii_pin_oe_n == gpio_oe_n)
    else $error("external PHY pins not under GPIO");
  a_err_drop:
    assert property (rx_in_valid && rx_in_ready && rx_in_error && sh[0] |=> frame_dropped)
    else $error("errored byte not dropped");

  c_nak: cover property (bulk_in_token && rx_fifo_empty && sh[3]);
  c_stall: cover property ($rose(out_pipe_stall));
  c_drop: cover property (frame_dropped);
endmodule // hwcfg_checker

bind hwcfg_top hwcfg_checker hwcfg_checker_i (.*);
`default_nettype wire

// ===== verification/hwcfg_usb_host_model.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================================================
// Host side: bulk IN tokens and frame checker sync loss
module hwcfg_usb_host_model
  import hwcfg_pkg::*;
(
  // Clock
  input wire logic clk,
  // Requests from the bench
  input wire logic req_token,
  input wire logic req_sync,
  // Toward the block
  output logic bulk_in_token,
  output logic tx_frame_checker_sync_lost,
  input wire hwcfg_reply_t in_reply,
  // Reply as the host saw it
  output hwcfg_reply_t last_reply
);
  logic token_d;

  // One-cycle pulses; the reply is taken in the cycle after the token
  always_ff @(posedge clk)
  begin
    bulk_in_token <= req_token;
    tx_frame_checker_sync_lost <= req_sync;
    token_d <= bulk_in_token;
    if (token_d)
      last_reply <= in_reply;
  end
endmodule // hwcfg_usb_host_model
`default_nettype wire

// ===== verilog/hwcfg_led_timer.sv
`timescale 1ns/10ps
`default_nettype none

// Activity LED blinker with selectable on/off period
module hwcfg_led_timer
  import hwcfg_pkg::*;
#(
  parameter int SLOW_CYC = HWCFG_LED_SLOW_CYC
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Control
  input wire logic fast,
  input wire logic activity,
  // LED drive
  output logic led
);

  logic [31:0] count;
  logic busy;
  logic phase_off;

  // ==========================================================================
  // Phase timer: one on phase then one off phase per activity burst
  // ==========================================================================
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      count <= 32'h0;
      busy <= 1'b0;
      phase_off <= 1'b0;
      led <= 1'b0;
    end
    else if (!busy)
    begin
      if (activity)
      begin
        busy <= 1'b1;
        phase_off <= 1'b0;
        led <= 1'b1;
        count <= 32'h0;
      end
    end
    else if (count >= (fast ? 32'(HWCFG_LED_FAST_CYC) : 32'(SLOW_CYC)) - 32'h1)
    begin
      count <= 32'h0;
      led <= 1'b0;
      phase_off <= 1'b1;
      if (phase_off)
        busy <= 1'b0;
    end
    else
      count <= count + 32'h1;
  end

endmodule // hwcfg_led_timer

`default_nettype wire

// ===== verilog/hwcfg_pkg.sv
package hwcfg_pkg;

  // ==========================================================================
  // Register map (word-aligned byte addresses)
  // ==========================================================================
  localparam logic [11:0] HWCFG_ADDR_SETUP = 12'h014;
  localparam logic [11:0] HWCFG_ADDR_EVENTS = 12'h018;

  // ==========================================================================
  // Field positions of hardware_setup
  // ==========================================================================
  localparam int HWCFG_BIT_GUARD = 15;
  localparam int HWCFG_BIT_BOOST_HI = 14;
  localparam int HWCFG_BIT_BOOST_LO = 13;
  localparam int HWCFG_BIT_EMPTY_REPLY = 12;
  localparam int HWCFG_BIT_FAST_BLINK = 11;
  localparam int HWCFG_BIT_SHIFT_HI = 10;
  localparam int HWCFG_BIT_SHIFT_LO = 9;
  localparam int HWCFG_BIT_STALL_INH = 8;
  localparam int HWCFG_BIT_MII_EXPOSE = 7;
  localparam int HWCFG_BIT_ERR_DROP = 6;
  localparam int HWCFG_BIT_PHY_SOURCE = 2;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [1:0] HWCFG_BOOST_RESET = 2'h0;
  localparam logic [1:0] HWCFG_SHIFT_RESET = 2'h0;
  localparam logic HWCFG_BIT_RESET = 1'b0;

  // ==========================================================================
  // LED timing
  // ==========================================================================
  localparam int HWCFG_CLK_MHZ = 100;
  localparam int HWCFG_LED_SLOW_MS = 80;
  localparam int HWCFG_LED_FAST_US = 15;
  localparam int HWCFG_LED_SLOW_CYC = HWCFG_LED_SLOW_MS * 1000 * HWCFG_CLK_MHZ;
  localparam int HWCFG_LED_FAST_CYC = HWCFG_LED_FAST_US * HWCFG_CLK_MHZ;

  // ==========================================================================
  // Configuration carried to the datapath
  // ==========================================================================
  typedef struct packed {
    logic guard;
    logic [1:0] boost;
    logic empty_reply;
    logic fast_blink;
    logic [1:0] shift;
    logic stall_inhibit;
    logic mii_expose;
    logic err_drop;
  } hwcfg_fields_t;

  // Bulk IN reply codes
  typedef enum logic [1:0] {
    HWCFG_REPLY_NONE = 2'h0,
    HWCFG_REPLY_ZLP = 2'h1,
    HWCFG_REPLY_NAK = 2'h2
  } hwcfg_reply_t;

endpackage

// ===== verilog/hwcfg_top.sv
// How it works
// - With the guard bit set, protected fields keep their values over every reset except power-on.
// - The guard bit protects itself, so it survives non-power-on resets while set.
// - The two-bit drive boost selects normal, +4%, +8% or +12% drive and is guarded.
// - A bulk IN token on an empty receive FIFO gets a zero-length packet when the reply bit is 0, NAK when 1.
// - The fast-blink bit cuts the LED on and off times from 80 ms to about 15 us each.
// - Each receive packet starts with 0 to 3 padding bytes set by the shift field.
// - Loss of sync in the transmit frame checker stalls the bulk OUT pipe unless stall-inhibit is set.
// - In internal PHY mode the exposure bit turns the MII pins and the PHY interrupt pin into outputs.
// - With an external PHY the exposure bit does not affect the pins.
// - While exposure is on in internal PHY mode, CRS, MDC, MDIO, COL and TXD3..0 ignore their GPIO setup.
// - With the drop bit set, each received byte flagged as errored is discarded; the other bytes of its frame pass.
// - A read-only bit shows the PHY source, 0 internal and 1 external, and defines internal mode.
`timescale 1ns/10ps
`default_nettype none

module hwcfg_top
  import hwcfg_pkg::*;
#(
  parameter int LED_SLOW_CYC = HWCFG_LED_SLOW_CYC
)
(
  // Clock and resets
  input wire logic clk,
  input wire logic reset,
  input wire logic por,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // PHY source strap pin
  input wire logic phy_source_pin,
  // USB bulk IN / OUT events
  input wire logic bulk_in_token,
  input wire logic rx_fifo_empty,
  output hwcfg_reply_t in_reply,
  input wire logic tx_frame_checker_sync_lost,
  output logic out_pipe_stall,
  input wire logic out_stall_clear,
  // USB drive strength
  output logic [1:0] hs_drive_boost,
  // Receive byte stream in
  input wire logic rx_in_valid,
  input wire logic rx_in_sop,
  input wire logic rx_in_error,
  input wire logic [7:0] rx_in_data,
  // Receive byte stream out toward USB
  output logic rx_out_valid,
  output logic rx_out_sop,
  output logic [7:0] rx_out_data,
  output logic rx_in_ready,
  output logic frame_dropped,
  // Activity LED
  input wire logic activity,
  output logic activity_led,
  // MII pin muxing
  input wire logic [7:0] mii_int_out,
  input wire logic phy_irq_int_n,
  input wire logic [7:0] gpio_out,
  input wire logic [7:0] gpio_oe_n,
  output logic [7:0] mii_pin_out,
  output logic [7:0] mii_pin_oe_n,
  output logic phy_irq_n,
  output logic phy_irq_oe_n
);

  hwcfg_fields_t cfg;
  logic phy_sync1, phy_sync2, phy_source;
  logic access, wr_setup;
  logic [1:0] pad_left;
  logic held;
  logic [7:0] held_data;
  logic led_raw;

  // ==========================================================================
  // Strap synchroniser, followed continuously; only power-on reset clears it
  // ==========================================================================
  always_ff @(posedge clk)
  begin
    phy_sync1 <= phy_source_pin;
    phy_sync2 <= phy_sync1;
  end

  always_ff @(posedge clk)
  begin
    if (por)
      phy_source <= HWCFG_BIT_RESET;
    else
      phy_source <= phy_sync2;
  end

  // ==========================================================================
  // APB access decode
  // ==========================================================================
  assign access = psel && penable && pready;
  assign wr_setup = access && pwrite && (paddr == HWCFG_ADDR_SETUP);

  // One wait state: pready rises after the first access cycle
  always_ff @(posedge clk)
  begin
    if (por || reset)
      pready <= 1'b0;
    else
      pready <= psel && penable && !pready;
  end

  // Read data and error answer
  always_ff @(posedge clk)
  begin
    if (por || reset)
    begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end
    else if (psel && penable && !pready)
    begin
      prdata <= 32'h0;
      pslverr <= (paddr != HWCFG_ADDR_SETUP) && (paddr != HWCFG_ADDR_EVENTS);
      if (!pwrite && paddr == HWCFG_ADDR_SETUP)
      begin
        prdata[HWCFG_BIT_GUARD] <= cfg.guard;
        prdata[HWCFG_BIT_BOOST_HI:HWCFG_BIT_BOOST_LO] <= cfg.boost;
        prdata[HWCFG_BIT_EMPTY_REPLY] <= cfg.empty_reply;
        prdata[HWCFG_BIT_FAST_BLINK] <= cfg.fast_blink;
        prdata[HWCFG_BIT_SHIFT_HI:HWCFG_BIT_SHIFT_LO] <= cfg.shift;
        prdata[HWCFG_BIT_STALL_INH] <= cfg.stall_inhibit;
        prdata[HWCFG_BIT_MII_EXPOSE] <= cfg.mii_expose;
        prdata[HWCFG_BIT_ERR_DROP] <= cfg.err_drop;
        prdata[HWCFG_BIT_PHY_SOURCE] <= phy_source;
      end
      else if (!pwrite && paddr == HWCFG_ADDR_EVENTS)
        prdata[0] <= out_pipe_stall;
    end
  end

  // ==========================================================================
  // Guarded fields: power-on clears, other resets spare them when guarded
  // ==========================================================================
  always_ff @(posedge clk)
  begin
    if (por)
    begin
      cfg.guard <= HWCFG_BIT_RESET;
      cfg.boost <= HWCFG_BOOST_RESET;
    end
    else if (reset && !cfg.guard)
    begin
      cfg.guard <= HWCFG_BIT_RESET;
      cfg.boost <= HWCFG_BOOST_RESET;
    end
    else if (wr_setup && !reset)
    begin
      cfg.guard <= pwdata[HWCFG_BIT_GUARD];
      cfg.boost <= pwdata[HWCFG_BIT_BOOST_HI:HWCFG_BIT_BOOST_LO];
    end
  end

  // Unguarded fields: every reset restores them
  always_ff @(posedge clk)
  begin
    if (por || reset)
    begin
      cfg.empty_reply <= HWCFG_BIT_RESET;
      cfg.fast_blink <= HWCFG_BIT_RESET;
      cfg.shift <= HWCFG_SHIFT_RESET;
      cfg.stall_inhibit <= HWCFG_BIT_RESET;
      cfg.mii_expose <= HWCFG_BIT_RESET;
      cfg.err_drop <= HWCFG_BIT_RESET;
    end
    else if (wr_setup)
    begin
      cfg.empty_reply <= pwdata[HWCFG_BIT_EMPTY_REPLY];
      cfg.fast_blink <= pwdata[HWCFG_BIT_FAST_BLINK];
      cfg.shift <= pwdata[HWCFG_BIT_SHIFT_HI:HWCFG_BIT_SHIFT_LO];
      cfg.stall_inhibit <= pwdata[HWCFG_BIT_STALL_INH];
      cfg.mii_expose <= pwdata[HWCFG_BIT_MII_EXPOSE];
      cfg.err_drop <= pwdata[HWCFG_BIT_ERR_DROP];
    end
  end

  // Boost level to USB PHY
  always_ff @(posedge clk)
  begin
    if (por)
      hs_drive_boost <= HWCFG_BOOST_RESET;
    else
      hs_drive_boost <= cfg.boost;
  end

  // ==========================================================================
  // Bulk IN reply on empty FIFO
  // ==========================================================================
  always_ff @(posedge clk)
  begin
    if (por || reset)
      in_reply <= HWCFG_REPLY_NONE;
    else if (bulk_in_token && rx_fifo_empty)
      in_reply <= cfg.empty_reply ? HWCFG_REPLY_NAK : HWCFG_REPLY_ZLP;
    else
      in_reply <= HWCFG_REPLY_NONE;
  end

  // ==========================================================================
  // Bulk OUT stall: set wins over clear; write 1 to event bit 0 also clears
  // ==========================================================================
  always_ff @(posedge clk)
  begin
    if (por || reset)
      out_pipe_stall <= 1'b0;
    else if (tx_frame_checker_sync_lost && !cfg.stall_inhibit)
      out_pipe_stall <= 1'b1;
    else if (out_stall_clear || (access && pwrite && paddr == HWCFG_ADDR_EVENTS && pwdata[0]))
      out_pipe_stall <= 1'b0;
  end

  // ==========================================================================
  // Receive path: lead padding and errored byte drop
  // ==========================================================================
  always_ff @(posedge clk)
  begin
    if (por || reset)
    begin
      pad_left <= 2'h0;
      held <= 1'b0;
      held_data <= 8'h00;
      rx_out_valid <= 1'b0;
      rx_out_sop <= 1'b0;
      rx_out_data <= 8'h00;
      rx_in_ready <= 1'b0;
      frame_dropped <= 1'b0;
    end
    else
    begin
      rx_out_valid <= 1'b0;
      rx_out_sop <= 1'b0;
      frame_dropped <= 1'b0;
      rx_in_ready <= (pad_left == 2'h0) && !held && !(rx_in_valid && rx_in_ready && rx_in_sop && cfg.shift != 2'h0);
      if (pad_left != 2'h0)
      begin
        rx_out_valid <= 1'b1;
        rx_out_data <= 8'h00;
        pad_left <= pad_left - 2'h1;
      end
      else if (held)
      begin
        // Start byte after its pads, marked as start again
        rx_out_valid <= 1'b1;
        rx_out_sop <= 1'b1;
        rx_out_data <= held_data;
        held <= 1'b0;
      end
      else if (rx_in_valid && rx_in_ready)
      begin
        if (rx_in_error && cfg.err_drop)
          frame_dropped <= 1'b1;
        else if (rx_in_sop && cfg.shift != 2'h0)
        begin
          // Start byte is already taken: park it while the pads go out
          rx_out_valid <= 1'b1;
          rx_out_sop <= 1'b1;
          rx_out_data <= 8'h00;
          held_data <= rx_in_data;
          held <= 1'b1;
          pad_left <= cfg.shift - 2'h1;
        end
        else
        begin
          rx_out_valid <= 1'b1;
          rx_out_sop <= rx_in_sop;
          rx_out_data <= rx_in_data;
        end
      end
    end
  end

  // ==========================================================================
  // Activity LED
  // ==========================================================================
  hwcfg_led_timer #(
    .SLOW_CYC(LED_SLOW_CYC)
  ) u_led (
    .clk(clk),
    .reset(por || reset),
    .fast(cfg.fast_blink),
    .activity(activity),
    .led(led_raw)
  );

  always_ff @(posedge clk)
  begin
    if (por || reset)
      activity_led <= 1'b0;
    else
      activity_led <= led_raw;
  end

  // ==========================================================================
  // MII pin exposure, priority over GPIO, internal PHY only
  // ==========================================================================
  always_ff @(posedge clk)
  begin
    if (por || reset)
    begin
      mii_pin_out <= 8'h00;
      mii_pin_oe_n <= 8'hFF;
      phy_irq_n <= 1'b1;
      phy_irq_oe_n <= 1'b1;
    end
    else if (cfg.mii_expose && !phy_source)
    begin
      mii_pin_out <= mii_int_out;
      mii_pin_oe_n <= 8'h00;
      phy_irq_n <= phy_irq_int_n;
      phy_irq_oe_n <= 1'b0;
    end
    else
    begin
      mii_pin_out <= gpio_out;
      mii_pin_oe_n <= gpio_oe_n;
      phy_irq_n <= 1'b1;
      phy_irq_oe_n <= 1'b1;
    end
  end

endmodule // hwcfg_top

`default_nettype wire
